//--- src/csb_map.svh
// Purpose: Offsets, field positions, reset values and counts of the status buffer
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes:   Included by the check, copy management and top modules and by the bench
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH

`define CSB_CTRL_OFS     8'h00
`define CSB_IEN_OFS      8'h04
`define CSB_ISTAT_OFS    8'h08
`define CSB_STAT_OFS     8'h0c
`define CSB_EBUF_BASE    8'h20
`define CSB_UBUF_BASE    8'h80

`define CSB_CTRL_RST     8'h00
`define CSB_IEN_RST      2'h0
`define CSB_IRQ_D2E      0
`define CSB_IRQ_E2F      1

`define CSB_BUF_WORDS    24
`define CSB_RESERVED     5
`define CSB_COPY_POS     13
`define CSB_GEN_POS      0
`define CSB_CHECK_INIT   8'hff
`define CSB_CHECK_POLY   8'h1d

`endif

//--- src/csb_pkg.sv
// Purpose: Types shared by the channel status buffer files
// Assumes: Nothing beyond the map header
// Notes:   Field order of ctrl_s matches the control register bits 7..0
package csb_pkg;

	typedef enum logic [1:0] {
		HW_SOFT,
		HW_PINS,
		HW_SERIAL
	} hwmode_e;

	typedef struct packed {
		hwmode_e hw_mode;
		logic    clocks_active;
		logic    sel_b;
		logic    two_byte;
		logic    reserve;
		logic    inh_e2f;
		logic    inh_d2e;
	} ctrl_s;

	typedef struct packed {
		logic       sel;
		logic       enable;
		logic       write;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [3:0] strb;
	} apb_req_s;

endpackage : csb_pkg

//--- src/csb_block_check.sv
// Purpose: Block check byte over the leading bits of a status block
// Assumes: bits_in[BITS-1] is the earliest bit of the serial stream
// Notes:   Purely combinational; one instance per channel
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"
module csb_block_check #(
	parameter int BITS = 184
)(
	input  wire logic [BITS-1:0] bits_in,
	output logic      [7:0]      check_byte
);

	logic [7:0] c;
	logic       fb;

	always_comb
	begin
		c  = `CSB_CHECK_INIT;
		fb = 1'b0;
		for (int i = BITS - 1; i >= 0; i--)
		begin
			fb = bits_in[i] ^ c[7];
			c  = {c[6:0], 1'b0} ^ (fb ? `CSB_CHECK_POLY : 8'h00);
		end
		check_byte = c;
	end

endmodule : csb_block_check
`default_nettype wire

//--- src/csb_copy_mgmt.sv
// Purpose: Copy management override of the first two status bytes
// Assumes: head_in[15] is the earliest bit, i.e. the professional flag
// Notes:   Only consumer blocks are touched; serial-pin mode acts at the output
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"
module csb_copy_mgmt
	import csb_pkg::*;
(
	input  wire logic [15:0] head_in,
	input  wire hwmode_e     mode,
	input  wire logic        copy_permit,
	input  wire logic        original_source,
	output logic      [15:0] head_out
);

	always_comb
	begin
		head_out = head_in;
		case (mode)
			HW_PINS:
			begin
				if (!head_in[15])
				begin
					head_out[`CSB_COPY_POS] = copy_permit;
					head_out[`CSB_GEN_POS]  = original_source;
				end
			end
			default:
			begin
				head_out = head_in;
			end
		endcase
	end

endmodule : csb_copy_mgmt
`default_nettype wire

//--- src/csb_top.sv
// Purpose: Three-stage channel status block buffer with APB host access
// Assumes: Frame strobes are one cycle long and at least two cycles apart
// Notes:   RX strobes mark the input timebase, TX strobes the output one
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"
module csb_top
	import csb_pkg::*;
#(
	parameter int WORDS = `CSB_BUF_WORDS
)(
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic             PREADY,
	output logic      [31:0] PRDATA,
	output logic             PSLVERR,
	input  wire logic        RX_FRAME_STB,
	input  wire logic        RX_BLOCK_START,
	input  wire logic        RX_CBIT_A,
	input  wire logic        RX_CBIT_B,
	input  wire logic        TX_FRAME_STB,
	input  wire logic        TX_CS_SERIAL,
	input  wire logic        COPY_PERMIT,
	input  wire logic        ORIGINAL_SOURCE,
	output logic             TX_CBIT_A,
	output logic             TX_CBIT_B,
	output logic             TX_BLOCK_START,
	output logic             INT
);

	localparam int             NB   = 8 * WORDS;
	localparam int             IW   = $clog2(NB);
	localparam logic [IW-1:0]  LAST = IW'(NB - 1);
	localparam logic [7:0]     EEND = 8'(`CSB_EBUF_BASE + 4 * WORDS);
	localparam logic [7:0]     UEND = 8'(`CSB_UBUF_BASE + 4 * WORDS);

	////////////////////////////////////////////////////////////////////////////
	// Storage
	ctrl_s              ctrl_q;
	logic [1:0]         ien_q;
	logic [1:0]         istat_q;
	logic [1:0][NB-1:0] d_q;
	logic [1:0][NB-1:0] f_q;
	logic [15:0]        e_q [WORDS];
	logic [15:0]        u_q [WORDS];
	logic [IW-1:0]      rx_idx_q;
	logic [IW-1:0]      tx_idx_q;
	logic               rx_sync_q;
	logic               d2e_go_q;
	logic               pready_q;
	logic               pslverr_q;
	logic [31:0]        prdata_q;
	logic               int_q;
	logic               txa_q;
	logic               txb_q;
	logic               txs_q;

	////////////////////////////////////////////////////////////////////////////
	// APB decode
	apb_req_s req;
	assign req = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB};

	wire        setup     = req.sel & ~req.enable;
	wire        fire      = req.sel & req.enable & pready_q;
	wire        wr        = fire & req.write;
	wire        sel_ctrl  = req.addr == `CSB_CTRL_OFS;
	wire        sel_ien   = req.addr == `CSB_IEN_OFS;
	wire        sel_istat = req.addr == `CSB_ISTAT_OFS;
	wire        sel_stat  = req.addr == `CSB_STAT_OFS;
	wire        aligned   = req.addr[1:0] == 2'h0;
	wire        sel_ebuf  = aligned & req.addr >= `CSB_EBUF_BASE & req.addr < EEND;
	wire        sel_ubuf  = aligned & req.addr >= `CSB_UBUF_BASE & req.addr < UEND;
	// Buffers only answer once the clocks are declared running
	wire        buf_ok    = ctrl_q.clocks_active;
	wire        addr_err  = ~(sel_ctrl | sel_ien | sel_istat | sel_stat |
	                          ((sel_ebuf | sel_ubuf) & buf_ok));
	wire [7:0]  eoff      = req.addr - `CSB_EBUF_BASE;
	wire [7:0]  uoff      = req.addr - `CSB_UBUF_BASE;
	wire [4:0]  widx      = eoff[6:2];
	wire [4:0]  uidx      = uoff[6:2];
	wire        ebuf_wr   = wr & sel_ebuf & buf_ok;
	wire        ubuf_wr   = wr & sel_ubuf & buf_ok;
	wire [15:0] eword     = sel_ebuf ? e_q[widx] : 16'h0000;
	wire [15:0] uword     = sel_ubuf ? u_q[uidx] : 16'h0000;
	// One-byte reads return the chosen half, two-byte reads A above B
	wire [7:0]  ebyte     = ctrl_q.sel_b ? eword[7:0] : eword[15:8];
	wire [31:0] ebuf_rd   = ctrl_q.two_byte ? {16'h0000, eword} :
	                        {24'h000000, ebyte};
	wire [31:0] stat_rd   = {15'h0000, tx_idx_q, rx_idx_q, rx_sync_q};
	wire [31:0] rdata     = addr_err  ? 32'h00000000 :
	                        sel_ctrl  ? {24'h000000, ctrl_q} :
	                        sel_ien   ? {30'h00000000, ien_q} :
	                        sel_istat ? {30'h00000000, istat_q} :
	                        sel_stat  ? stat_rd :
	                        sel_ebuf  ? ebuf_rd : {16'h0000, uword};

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end
		else
		begin
			pready_q  <= setup;
			pslverr_q <= setup & addr_err;
			prdata_q  <= setup ? rdata : prdata_q;
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			ctrl_q <= ctrl_s'(`CSB_CTRL_RST);
			ien_q  <= `CSB_IEN_RST;
		end
		else
		begin
			if (wr & sel_ctrl & req.strb[0])
				ctrl_q <= ctrl_s'(req.wdata[7:0]);
			if (wr & sel_ien & req.strb[0])
				ien_q <= req.wdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive stage, input timebase
	wire [IW-1:0] rx_cur  = RX_BLOCK_START ? {IW{1'b0}} : rx_idx_q;
	wire          rx_syn  = rx_sync_q | RX_BLOCK_START;
	// Blocks are handed on only once a start marker has been seen since reset
	wire          rx_last = RX_FRAME_STB & rx_syn & rx_cur == LAST;

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			rx_idx_q  <= {IW{1'b0}};
			rx_sync_q <= 1'b0;
			d2e_go_q  <= 1'b0;
			d_q       <= '0;
		end
		else
		begin
			d2e_go_q <= rx_last & ~ctrl_q.inh_d2e;
			if (RX_FRAME_STB)
			begin
				rx_sync_q                <= rx_syn;
				rx_idx_q                 <= rx_cur == LAST ? {IW{1'b0}} : rx_cur + 1'b1;
				d_q[0][NB - 1 - rx_cur]  <= RX_CBIT_A;
				d_q[1][NB - 1 - rx_cur]  <= RX_CBIT_B;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Host stage and user store, one entry per word
	for (genvar w = 0; w < WORDS; w++)
	begin : g_word
		localparam int HI = NB - 1 - 8 * w;
		// The reserved head keeps host values across receive transfers
		wire        load  = d2e_go_q & ~(ctrl_q.reserve & (w < `CSB_RESERVED));
		wire [15:0] base  = load ? {d_q[0][HI -: 8], d_q[1][HI -: 8]} : e_q[w];
		wire        hit   = ebuf_wr & widx == 5'(w);
		wire        uhit  = ubuf_wr & uidx == 5'(w);
		wire [7:0]  hi_b  = req.strb[1] ? req.wdata[15:8] : base[15:8];
		wire [7:0]  lo_b  = req.strb[0] ? req.wdata[7:0] : base[7:0];
		wire [15:0] one_b = req.strb[0] ? {2{req.wdata[7:0]}} : base;
		wire [15:0] e_d   = ~hit ? base : ctrl_q.two_byte ? {hi_b, lo_b} : one_b;
		wire [15:0] u_d   = uhit ? {req.strb[1] ? req.wdata[15:8] : u_q[w][15:8],
		                            req.strb[0] ? req.wdata[7:0] : u_q[w][7:0]} : u_q[w];

		always_ff @(posedge MCLK)
		begin
			if (RST)
			begin
				e_q[w] <= 16'h0000;
				u_q[w] <= 16'h0000;
			end
			else
			begin
				e_q[w] <= e_d;
				u_q[w] <= u_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-channel copy management and check byte on the way to the last stage
	wire [1:0][NB-1:0] f_blk;
	wire [1:0][7:0]    crc_w;

	for (genvar g = 0; g < 2; g++)
	begin : g_chan
		wire [NB-1:0] e_blk;
		wire [15:0]   head;
		for (genvar w = 0; w < WORDS; w++)
		begin : g_pack
			assign e_blk[NB - 1 - 8 * w -: 8] = e_q[w][8 * (1 - g) +: 8];
		end
		csb_copy_mgmt u_cm (
			.head_in         (e_blk[NB-1 -: 16]),
			.mode            (ctrl_q.hw_mode),
			.copy_permit     (COPY_PERMIT),
			.original_source (ORIGINAL_SOURCE),
			.head_out        (head)
		);
		csb_block_check #(.BITS(NB - 8)) u_bc (
			.bits_in    ({head, e_blk[NB-17:8]}),
			.check_byte (crc_w[g])
		);
		// Professional blocks carry the generated byte in place of the host's
		assign f_blk[g] = {head, e_blk[NB-17:8], head[15] ? crc_w[g] : e_blk[7:0]};
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit stage, output timebase
	wire tx_last = TX_FRAME_STB & tx_idx_q == LAST;
	wire e2f_go  = tx_last & ~ctrl_q.inh_e2f;
	wire serial  = ctrl_q.hw_mode == HW_SERIAL;

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			tx_idx_q <= {IW{1'b0}};
			f_q      <= '0;
			txa_q    <= 1'b0;
			txb_q    <= 1'b0;
			txs_q    <= 1'b0;
		end
		else
		begin
			if (TX_FRAME_STB)
			begin
				txa_q    <= serial ? TX_CS_SERIAL : f_q[0][NB - 1 - tx_idx_q];
				txb_q    <= serial ? TX_CS_SERIAL : f_q[1][NB - 1 - tx_idx_q];
				txs_q    <= tx_idx_q == {IW{1'b0}};
				tx_idx_q <= tx_last ? {IW{1'b0}} : tx_idx_q + 1'b1;
			end
			// Loading after the last bit leaves the outgoing block intact
			if (e2f_go)
				f_q <= f_blk;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transfer interrupts; a new event beats a same-cycle clear
	wire [1:0] ev    = {e2f_go, d2e_go_q};
	wire [1:0] clr   = (wr & sel_istat & req.strb[0]) ? req.wdata[1:0] : 2'h0;
	wire [1:0] ist_d = (istat_q & ~clr) | ev;

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			istat_q <= 2'h0;
			int_q   <= 1'b0;
		end
		else
		begin
			istat_q <= ist_d;
			int_q   <= |(istat_q & ien_q);
		end
	end

	assign PREADY         = pready_q;
	assign PSLVERR        = pslverr_q;
	assign PRDATA         = prdata_q;
	assign TX_CBIT_A      = txa_q;
	assign TX_CBIT_B      = txb_q;
	assign TX_BLOCK_START = txs_q;
	assign INT            = int_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_D2E_INHIBIT: assert property (@(posedge MCLK) disable iff (RST)
		rx_last && ctrl_q.inh_d2e |=> !d2e_go_q)
		else $error("receive transfer despite inhibit");

	AST_D2E_COPY: assert property (@(posedge MCLK) disable iff (RST)
		d2e_go_q && !ebuf_wr |=> e_q[WORDS-1] == $past({d_q[0][7:0], d_q[1][7:0]}))
		else $error("receive transfer did not copy last word");

	AST_RESERVE: assert property (@(posedge MCLK) disable iff (RST)
		d2e_go_q && ctrl_q.reserve && !ebuf_wr |=> $stable(e_q[0]) && $stable(e_q[4]))
		else $error("reserved head overwritten");

	AST_E2F_INHIBIT: assert property (@(posedge MCLK) disable iff (RST)
		tx_last && ctrl_q.inh_e2f |=> $stable(f_q))
		else $error("transmit stage loaded despite inhibit");

	AST_IRQ: assert property (@(posedge MCLK) disable iff (RST)
		d2e_go_q && ien_q[0] ##1 ien_q[0] |=> INT)
		else $error("enabled transfer raised no interrupt");

	AST_CHECK_BYTE: assert property (@(posedge MCLK) disable iff (RST)
		e2f_go && f_blk[0][NB-1] |=> f_q[0][7:0] == $past(crc_w[0]))
		else $error("professional block lacks check byte");

	AST_ONE_BYTE_WR: assert property (@(posedge MCLK) disable iff (RST)
		ebuf_wr && !ctrl_q.two_byte && req.strb[0]
		|=> e_q[$past(widx)] == {2{$past(req.wdata[7:0])}})
		else $error("one-byte write not stored in both halves");

	AST_ONE_BYTE_RD: assert property (@(posedge MCLK) disable iff (RST)
		setup && sel_ebuf && buf_ok && !ctrl_q.two_byte
		|=> PRDATA == {24'h000000, $past(ctrl_q.sel_b ? eword[7:0] : eword[15:8])})
		else $error("one-byte read returned wrong half");

	AST_TWO_BYTE_RD: assert property (@(posedge MCLK) disable iff (RST)
		setup && sel_ebuf && buf_ok && ctrl_q.two_byte |=> PRDATA == {16'h0000, $past(eword)})
		else $error("two-byte read order wrong");

	AST_RX_ORDER: assert property (@(posedge MCLK) disable iff (RST)
		RX_FRAME_STB && RX_BLOCK_START |=> d_q[0][NB-1] == $past(RX_CBIT_A))
		else $error("first serial bit not in byte MSB");

endmodule : csb_top
`default_nettype wire

//--- tb/csb_link_model.sv
// Purpose: Receiver frame source and transmitter frame sink around the buffer
// Assumes: Stream bit n of a block is blk[191-n]; strobes are 2 and 4 cycles apart
// Notes:   Data lines flip between strobes so a stale bit is never read as valid
`timescale 1ns/1ns
`default_nettype none
module csb_link_model (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [191:0] blk_a,
	input  wire logic [191:0] blk_b,
	input  wire logic         tx_en,
	input  wire logic         tx_a,
	input  wire logic         tx_b,
	input  wire logic         tx_start,
	output logic              rx_stb,
	output logic              rx_start,
	output logic              rx_a,
	output logic              rx_b,
	output logic              tx_stb,
	output logic      [191:0] cap_a,
	output logic      [191:0] cap_b,
	output int                nblk
);
	logic [1:0] ph;
	logic       seen;
	int         idx;

	initial
	begin
		rx_stb = 1'b0;
		rx_start = 1'b0;
		rx_a = 1'b0;
		rx_b = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One whole block, frame 0 flagged, earliest bit first
	task automatic send_block();
		for (int n = 0; n < 192; n++)
		begin
			@(posedge clk);
			rx_stb   <= 1'b1;
			rx_start <= (n == 0);
			rx_a     <= blk_a[191-n];
			rx_b     <= blk_b[191-n];
			@(posedge clk);
			rx_stb   <= 1'b0;
			rx_a     <= ~rx_a;
			rx_b     <= ~rx_b;
		end
	endtask : send_block

	////////////////////////////////////////////////////////////////////////////////
	// Bits are sampled one cycle after the strobe was seen by the buffer
	always @(posedge clk)
	begin
		if (rst)
		begin
			ph <= 2'h0;
			tx_stb <= 1'b0;
			seen <= 1'b0;
			nblk <= 0;
			idx = 192;
		end
		else
		begin
			ph <= ph + 2'h1;
			tx_stb <= tx_en && ph == 2'h0;
			seen <= tx_stb;
			if (seen)
			begin
				idx = tx_start ? 0 : idx + 1;
				if (tx_start)
					nblk <= nblk + 1;
				if (idx < 192)
				begin
					cap_a[191-idx] <= tx_a;
					cap_b[191-idx] <= tx_b;
				end
			end
		end
	end
endmodule : csb_link_model
`default_nettype wire

//--- tb/channel_status_block_buffer_bench.sv
// Purpose: Self-checking bench for the three-stage status block buffer
// Assumes: Byte strobes held all set; the slave's wait states are waited out
// Notes:   Host keeps clocks active and sets each inhibit to check that it blocks its own transfer
`timescale 1ns/1ns
`default_nettype none
`include "csb_map.svh"
module channel_status_block_buffer_bench import csb_pkg::*;
;
	logic         MCLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, INT;
	logic [7:0]   PADDR;
	logic [31:0]  PWDATA, PRDATA, last_r;
	logic [3:0]   PSTRB;
	logic         RX_FRAME_STB, RX_BLOCK_START, RX_CBIT_A, RX_CBIT_B, TX_FRAME_STB;
	logic         TX_CS_SERIAL, TX_CBIT_A, TX_CBIT_B, TX_BLOCK_START, last_e, tx_en;
	logic         COPY_PERMIT, ORIGINAL_SOURCE;
	logic [191:0] blk_a, blk_b, ea, eb, sa, sb, cap_a, cap_b;
	int           err_total, num_checks, nblk;

	csb_top dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA),
		.PSLVERR(PSLVERR), .RX_FRAME_STB(RX_FRAME_STB), .RX_BLOCK_START(RX_BLOCK_START),
		.RX_CBIT_A(RX_CBIT_A), .RX_CBIT_B(RX_CBIT_B), .TX_FRAME_STB(TX_FRAME_STB),
		.TX_CS_SERIAL(TX_CS_SERIAL), .COPY_PERMIT(COPY_PERMIT),
		.ORIGINAL_SOURCE(ORIGINAL_SOURCE),
		.TX_CBIT_A(TX_CBIT_A), .TX_CBIT_B(TX_CBIT_B), .TX_BLOCK_START(TX_BLOCK_START),
		.INT(INT));
	csb_link_model model (.clk(MCLK), .rst(RST), .blk_a(blk_a), .blk_b(blk_b),
		.tx_en(tx_en), .tx_a(TX_CBIT_A), .tx_b(TX_CBIT_B), .tx_start(TX_BLOCK_START),
		.rx_stb(RX_FRAME_STB), .rx_start(RX_BLOCK_START), .rx_a(RX_CBIT_A),
		.rx_b(RX_CBIT_B), .tx_stb(TX_FRAME_STB), .cap_a(cap_a), .cap_b(cap_b), .nblk(nblk));

	always #5 MCLK = ~MCLK;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test();
		if (err_total == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// Pready is read just after each edge, so it is the value that edge sampled
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge MCLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do
		begin
			@(posedge MCLK);
			t++;
		end
		while (PREADY !== 1'b1 && t < 50);
		last_r = PRDATA;
		last_e = PSLVERR;
		if (t >= 50)
			err_total++;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : bus

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp_r, input logic exp_e);
		bus(w, a, d);
		if (!w)
			chk(last_r, exp_r);
		chk({31'h0, last_e}, {31'h0, exp_e});
	endtask : xfer

	function automatic logic [7:0] eadr(input int i);
		return 8'(`CSB_EBUF_BASE + 4 * i);
	endfunction : eadr

	function automatic logic [31:0] ew(input logic [191:0] a, input logic [191:0] b,
		input int i);
		return {16'h0, a[191-8*i -: 8], b[191-8*i -: 8]};
	endfunction : ew

	function automatic logic [7:0] crc(input logic [191:0] b);
		logic [7:0] c;
		c = 8'hff;
		for (int n = 0; n < 184; n++)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ b[191-n]) ? 8'h1d : 8'h00);
		return c;
	endfunction : crc

	task automatic rd_all(input logic [191:0] a, input logic [191:0] b);
		for (int i = 0; i < 24; i++)
			xfer(1'b0, eadr(i), 32'h0, ew(a, b, i), 1'b0);
	endtask : rd_all

	task automatic starts(input int n);
		int k;
		k = nblk;
		while (nblk < k + n)
			@(posedge MCLK);
		@(negedge MCLK);
	endtask : starts

	task automatic tx_cmp(input logic [191:0] a, input logic [191:0] b);
		starts(3);
		if (a[191])
			a[7:0] = crc(a);
		if (b[191])
			b[7:0] = crc(b);
		chk(32'(cap_a === a), 32'h1);
		chk(32'(cap_b === b), 32'h1);
	endtask : tx_cmp

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (40000) @(posedge MCLK);
		err_total++;
		finish_test();
	end

	initial
	begin
		MCLK = 1'b0;
		RST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		PSTRB = 4'hf;
		TX_CS_SERIAL = 1'b0;
		COPY_PERMIT = 1'b1;
		ORIGINAL_SOURCE = 1'b0;
		tx_en = 1'b0;
		blk_a = {16{12'ha5c}};
		blk_b = {12{16'h3c96}};
		err_total = 0;
		num_checks = 0;
		repeat (3) @(posedge MCLK);
		RST <= 1'b0;
		xfer(1'b0, `CSB_CTRL_OFS, 32'h0, 32'(`CSB_CTRL_RST), 1'b0);
		xfer(1'b0, `CSB_IEN_OFS, 32'h0, 32'(`CSB_IEN_RST), 1'b0);
		xfer(1'b0, `CSB_STAT_OFS, 32'h0, 32'h0, 1'b0);
		xfer(1'b0, eadr(0), 32'h0, 32'h0, 1'b1);
		xfer(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
		xfer(1'b1, `CSB_CTRL_OFS, 32'h28, 32'h0, 1'b0);
		xfer(1'b1, `CSB_UBUF_BASE + 8'h04, 32'hbeef, 32'h0, 1'b0);
		xfer(1'b0, `CSB_UBUF_BASE + 8'h04, 32'h0, 32'hbeef, 1'b0);
		for (int i = 0; i < 24; i++)
		begin
			ea[191-8*i -: 8] = 8'(i * 9 + 1);
			eb[191-8*i -: 8] = 8'(8'hf0 - i);
			xfer(1'b1, eadr(i), ew(ea, eb, i), 32'h0, 1'b0);
		end
		rd_all(ea, eb);
		for (int s = 0; s < 2; s++)
		begin
			xfer(1'b1, `CSB_CTRL_OFS, 32'h20 | 32'(s << 4), 32'h0, 1'b0);
			for (int i = 0; i < 24; i++)
				xfer(1'b0, eadr(i), 32'h0, s ? ew(ea, eb, i) & 32'hff
					: ew(ea, eb, i) >> 8, 1'b0);
		end
		for (int i = 0; i < 24; i++)
		begin
			ea[191-8*i -: 8] = 8'(8'h40 + i);
			eb[191-8*i -: 8] = 8'(8'h40 + i);
			xfer(1'b1, eadr(i), 32'h0000_ff00 | 32'(8'h40 + i), 32'h0, 1'b0);
		end
		xfer(1'b1, `CSB_CTRL_OFS, 32'h28, 32'h0, 1'b0);
		rd_all(ea, eb);
		xfer(1'b1, `CSB_IEN_OFS, 32'h3, 32'h0, 1'b0);
		tx_en <= 1'b1;
		tx_cmp(ea, eb);
		xfer(1'b0, `CSB_ISTAT_OFS, 32'h0, 32'h2, 1'b0);
		chk(32'(INT), 32'h1);
		xfer(1'b1, `CSB_ISTAT_OFS, 32'h3, 32'h0, 1'b0);
		model.send_block();
		repeat (4) @(posedge MCLK);
		bus(1'b0, `CSB_ISTAT_OFS, 32'h0);
		chk(last_r & 32'h1, 32'h1);
		rd_all(blk_a, blk_b);
		ea = blk_a;
		eb = blk_b;
		tx_cmp(ea, eb);
		xfer(1'b1, `CSB_CTRL_OFS, 32'h29, 32'h0, 1'b0);
		blk_a = ~blk_a;
		blk_b = ~blk_b;
		model.send_block();
		repeat (4) @(posedge MCLK);
		rd_all(ea, eb);
		sa = ea;
		sb = eb;
		xfer(1'b1, `CSB_CTRL_OFS, 32'h2a, 32'h0, 1'b0);
		xfer(1'b1, eadr(5), 32'h7788, 32'h0, 1'b0);
		tx_cmp(sa, sb);
		xfer(1'b1, `CSB_CTRL_OFS, 32'h2c, 32'h0, 1'b0);
		model.send_block();
		repeat (4) @(posedge MCLK);
		ea[151:0] = blk_a[151:0];
		eb[151:0] = blk_b[151:0];
		rd_all(ea, eb);
		// Pin values chosen so both overridden bits of the consumer block flip
		COPY_PERMIT <= 1'b0;
		ORIGINAL_SOURCE <= 1'b1;
		xfer(1'b1, `CSB_CTRL_OFS, 32'h68, 32'h0, 1'b0);
		sb = eb;
		sb[189] = 1'b0;
		sb[176] = 1'b1;
		tx_cmp(ea, sb);
		TX_CS_SERIAL <= 1'b1;
		xfer(1'b1, `CSB_CTRL_OFS, 32'ha8, 32'h0, 1'b0);
		starts(2);
		chk(32'(cap_a === {192{1'b1}} && cap_b === {192{1'b1}}), 32'h1);
		finish_test();
	end
endmodule : channel_status_block_buffer_bench
`default_nettype wire
